// >>> hw/sfr_pkg.sv
// sfr_pkg: flag positions, reserved layout, reset value and request types
// for the processor flags word block.
// assumes: a single 40 MHz clock domain shared by all users of these types.
package sfr_pkg;

   localparam int unsigned SFR_W       = 32;
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
   // reserved: 1, 3, 5, 15, 22..31
   localparam logic [31:0] RSVD_MASK   = 32'hFFC0_802A;
   localparam logic [31:0] RSVD_ONES   = 32'h0000_0002;
   // bits that the accumulator byte transfer may load: 7, 6, 4, 2, 0
   localparam logic [7:0]  ACC_LOAD_MASK = 8'hD5;

   localparam int unsigned BIT_CARRY  = 0;
   localparam int unsigned BIT_PARITY = 2;
   localparam int unsigned BIT_ADJUST = 4;
   localparam int unsigned BIT_ZERO   = 6;
   localparam int unsigned BIT_SIGN   = 7;
   localparam int unsigned BIT_INT_EN = 9;
   localparam int unsigned BIT_DIR    = 10;
   localparam int unsigned BIT_OVFL   = 11;

   typedef enum logic [2:0] {
      SFR_OP_ADD        = 3'h0,
      SFR_OP_ADD_CARRY  = 3'h1,
      SFR_OP_SUB        = 3'h2,
      SFR_OP_SUB_BORROW = 3'h3,
      SFR_OP_AND        = 3'h4,
      SFR_OP_OR         = 3'h5,
      SFR_OP_XOR        = 3'h6
   } sfr_alu_op_t;

   typedef enum logic [1:0] {
      SFR_SZ_8  = 2'h0,
      SFR_SZ_16 = 2'h1,
      SFR_SZ_32 = 2'h2
   } sfr_size_t;

   typedef enum logic [1:0] {
      SFR_CARRY_NONE  = 2'h0,
      SFR_CARRY_SET   = 2'h1,
      SFR_CARRY_CLEAR = 2'h2,
      SFR_CARRY_CPL   = 2'h3
   } sfr_carry_cmd_t;

   typedef enum logic [1:0] {
      SFR_BT_TEST  = 2'h0,
      SFR_BT_SET   = 2'h1,
      SFR_BT_RESET = 2'h2,
      SFR_BT_CPL   = 2'h3
   } sfr_bt_kind_t;

   typedef enum logic [2:0] {
      SFR_GRP_NONE      = 3'h0,
      SFR_GRP_LOAD_ACC  = 3'h1,
      SFR_GRP_STORE_ACC = 3'h2,
      SFR_GRP_PUSH16    = 3'h3,
      SFR_GRP_PUSH32    = 3'h4,
      SFR_GRP_POP16     = 3'h5,
      SFR_GRP_POP32     = 3'h6
   } sfr_grp_op_t;

   typedef struct packed {
      logic        valid;
      sfr_alu_op_t op;
      sfr_size_t   size;
      logic [31:0] a;
      logic [31:0] b;
   } sfr_alu_req_t;

   typedef struct packed {
      logic         valid;
      sfr_bt_kind_t kind;
      logic [4:0]   index;
      logic [31:0]  operand;
   } sfr_bt_req_t;

   typedef struct packed {
      logic [31:0] result;
      logic        carry;
      logic        parity;
      logic        adjust;
      logic        zero;
      logic        sign;
      logic        ovfl;
   } sfr_alu_res_t;

endpackage

// >>> hw/sfr_flags.sv
// sfr_flags: processor flags word, status flag generation, group transfers,
// task and interrupt save/restore, condition evaluation.
// assumes: the execution core issues at most one request of each group per
// cycle; the init pin is asynchronous; rst_b is the hardware reset.
//
// Operation
// - reset or init loads 00000002h
// - reserved bits fixed, bit1 one, others zero
// - no whole-word access; only group transfers
// - task suspend stores flags to save area
// - task switch reloads flags from save area
// - handler call pushes flags onto stack
// - handler via task saves to save area
// - carry flag from carry/borrow out top
// - parity flag on even ones, low byte
// - adjust flag on carry/borrow from bit3
// - zero flag when result is zero
// - sign flag copies result top bit
// - overflow flag on signed range overflow
// - only carry set/clear/complement directly
// - bit-test copies selected bit into carry
// - carry feeds add-carry and subtract-borrow
// - condition codes evaluate status flags
// - direction flag bit10 steps strings down
// - interrupt enable bit9 gates maskable interrupts
`timescale 1ns/1ps

module sfr_flags
   import sfr_pkg::*;
#(
   parameter int unsigned DATA_W = SFR_W
) (
   // clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   input  wire logic           init_pin,
   // arithmetic
   input  wire sfr_alu_req_t   alu_req,
   output logic [31:0]         alu_result_ff,
   // direct carry and bit test
   input  wire sfr_carry_cmd_t carry_cmd,
   input  wire sfr_bt_req_t    bt_req,
   output logic [31:0]         bt_operand_ff,
   // control flag commands
   input  wire logic           dir_set,
   input  wire logic           dir_clear,
   input  wire logic           int_en_set,
   input  wire logic           int_en_clear,
   // group transfers
   input  wire sfr_grp_op_t    grp_op,
   input  wire logic [31:0]    grp_data_in,
   output logic [7:0]          acc_byte_ff,
   output logic                stack_push_valid_ff,
   output logic [31:0]         stack_push_data_ff,
   // task and interrupt
   input  wire logic           task_suspend_req,
   input  wire logic           task_load_req,
   input  wire logic [31:0]    task_load_data,
   input  wire logic           int_entry_req,
   input  wire logic           int_via_task,
   output logic                task_save_valid_ff,
   output logic [31:0]         task_save_data_ff,
   // condition
   input  wire logic [3:0]     cond_code,
   output logic                cond_true,
   // state
   output logic [31:0]         flags_word,
   output logic                dir_step_down,
   output logic                int_enable
);

   initial begin
      if (DATA_W != 32) begin
         $error("sfr_flags: only a 32-bit flags word is supported");
      end
   end

   logic [31:0] flags_ff;
   logic [31:0] nxt_flags;
   logic        init_meta_ff;
   logic        init_sync_ff;
   sfr_alu_res_t alu_res;

   function automatic logic [31:0] fix_reserved(input logic [31:0] v);
      fix_reserved = (v & ~RSVD_MASK) | RSVD_ONES;
   endfunction

   function automatic logic [31:0] size_mask(input sfr_size_t sz);
      case (sz)
         SFR_SZ_8:  size_mask = 32'h0000_00FF;
         SFR_SZ_16: size_mask = 32'h0000_FFFF;
         default:   size_mask = 32'hFFFF_FFFF;
      endcase
   endfunction

   function automatic logic top_bit(input logic [32:0] v, input sfr_size_t sz);
      case (sz)
         SFR_SZ_8:  top_bit = v[7];
         SFR_SZ_16: top_bit = v[15];
         default:   top_bit = v[31];
      endcase
   endfunction

   function automatic logic carry_bit(input logic [32:0] v, input sfr_size_t sz);
      case (sz)
         SFR_SZ_8:  carry_bit = v[8];
         SFR_SZ_16: carry_bit = v[16];
         default:   carry_bit = v[32];
      endcase
   endfunction

   function automatic sfr_alu_res_t alu_eval(input sfr_alu_req_t rq, input logic cin);
      logic [32:0] am;
      logic [32:0] bm;
      logic [32:0] s;
      logic        sa;
      logic        sb;
      logic        sr;
      am = {1'b0, rq.a & size_mask(rq.size)};
      bm = {1'b0, rq.b & size_mask(rq.size)};
      s = 33'h0_0000_0000;
      alu_eval = '0;
      sa = top_bit(am, rq.size);
      sb = top_bit(bm, rq.size);
      case (rq.op)
         SFR_OP_ADD, SFR_OP_ADD_CARRY: begin
            // carry in only for the chaining add
            s = am + bm + {32'h0000_0000, cin & (rq.op == SFR_OP_ADD_CARRY)};
            alu_eval.carry = carry_bit(s, rq.size);
         end
         SFR_OP_SUB, SFR_OP_SUB_BORROW: begin
            s = am - bm - {32'h0000_0000, cin & (rq.op == SFR_OP_SUB_BORROW)};
            // masked operands: any borrow wraps through bit 32
            alu_eval.carry = s[32];
         end
         SFR_OP_AND: s = am & bm;
         SFR_OP_OR:  s = am | bm;
         default:    s = am ^ bm;
      endcase
      alu_eval.result = s[31:0] & size_mask(rq.size);
      sr = top_bit(s, rq.size);
      if (rq.op <= SFR_OP_SUB_BORROW) begin
         alu_eval.adjust = am[4] ^ bm[4] ^ s[4];
      end
      if (rq.op <= SFR_OP_ADD_CARRY) begin
         alu_eval.ovfl = (sa == sb) && (sr != sa);
      end else if (rq.op <= SFR_OP_SUB_BORROW) begin
         alu_eval.ovfl = (sa != sb) && (sr != sa);
      end
      alu_eval.parity = ~^alu_eval.result[7:0];
      alu_eval.zero   = (alu_eval.result == 32'h0000_0000);
      alu_eval.sign   = sr;
   endfunction

   function automatic logic cond_eval(input logic [3:0] cc, input logic [31:0] f);
      logic c;
      case (cc[3:1])
         3'h0: c = f[BIT_OVFL];
         3'h1: c = f[BIT_CARRY];
         3'h2: c = f[BIT_ZERO];
         3'h3: c = f[BIT_CARRY] | f[BIT_ZERO];
         3'h4: c = f[BIT_SIGN];
         3'h5: c = f[BIT_PARITY];
         3'h6: c = f[BIT_SIGN] ^ f[BIT_OVFL];
         default: c = (f[BIT_SIGN] ^ f[BIT_OVFL]) | f[BIT_ZERO];
      endcase
      // odd codes are the negated forms
      cond_eval = c ^ cc[0];
   endfunction

   assign alu_res = alu_eval(alu_req, flags_ff[BIT_CARRY]);

   // init pin crosses into clk domain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         init_meta_ff <= 1'b0;
         init_sync_ff <= 1'b0;
      end else begin
         init_meta_ff <= init_pin;
         init_sync_ff <= init_meta_ff;
      end
   end

   // one status update source per cycle, direction/interrupt commands alongside; restores beat both
   always_comb begin
      nxt_flags = flags_ff;
      if (task_load_req) begin
         nxt_flags = task_load_data;
      end else if (grp_op == SFR_GRP_POP32) begin
         nxt_flags = grp_data_in;
      end else if (grp_op == SFR_GRP_POP16) begin
         nxt_flags[15:0] = grp_data_in[15:0];
      end else begin
         if (grp_op == SFR_GRP_STORE_ACC) begin
            nxt_flags[7:0] = (flags_ff[7:0] & ~ACC_LOAD_MASK)
                           | (grp_data_in[7:0] & ACC_LOAD_MASK);
         end else if (alu_req.valid) begin
            // all six commit together
            nxt_flags[BIT_CARRY]  = alu_res.carry;
            nxt_flags[BIT_PARITY] = alu_res.parity;
            nxt_flags[BIT_ADJUST] = alu_res.adjust;
            nxt_flags[BIT_ZERO]   = alu_res.zero;
            nxt_flags[BIT_SIGN]   = alu_res.sign;
            nxt_flags[BIT_OVFL]   = alu_res.ovfl;
         end else if (bt_req.valid) begin
            nxt_flags[BIT_CARRY] = bt_req.operand[bt_req.index];
         end else begin
            case (carry_cmd)
               SFR_CARRY_SET:   nxt_flags[BIT_CARRY] = 1'b1;
               SFR_CARRY_CLEAR: nxt_flags[BIT_CARRY] = 1'b0;
               SFR_CARRY_CPL:   nxt_flags[BIT_CARRY] = ~flags_ff[BIT_CARRY];
               default:         nxt_flags[BIT_CARRY] = flags_ff[BIT_CARRY];
            endcase
         end
         // clear wins if both are asked at once
         if (dir_clear) begin
            nxt_flags[BIT_DIR] = 1'b0;
         end else if (dir_set) begin
            nxt_flags[BIT_DIR] = 1'b1;
         end
         if (int_en_clear) begin
            nxt_flags[BIT_INT_EN] = 1'b0;
         end else if (int_en_set) begin
            nxt_flags[BIT_INT_EN] = 1'b1;
         end
      end
      // software may write anything; reserved bits never take it
      nxt_flags = fix_reserved(nxt_flags);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_ff <= FLAGS_RESET;
      end else if (init_sync_ff) begin
         flags_ff <= FLAGS_RESET;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // datapath results
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alu_result_ff <= 32'h0000_0000;
         bt_operand_ff <= 32'h0000_0000;
      end else begin
         if (alu_req.valid) begin
            alu_result_ff <= alu_res.result;
         end
         if (bt_req.valid) begin
            case (bt_req.kind)
               SFR_BT_SET:   bt_operand_ff <= bt_req.operand | (32'h1 << bt_req.index);
               SFR_BT_RESET: bt_operand_ff <= bt_req.operand & ~(32'h1 << bt_req.index);
               SFR_BT_CPL:   bt_operand_ff <= bt_req.operand ^ (32'h1 << bt_req.index);
               default:      bt_operand_ff <= bt_req.operand;
            endcase
         end
      end
   end

   // outgoing copies use the value held before this cycle's update
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_byte_ff         <= 8'h02;
         stack_push_valid_ff <= 1'b0;
         stack_push_data_ff  <= 32'h0000_0000;
      end else begin
         if (grp_op == SFR_GRP_LOAD_ACC) begin
            acc_byte_ff <= flags_ff[7:0];
         end
         stack_push_valid_ff <= 1'b0;
         if (int_entry_req && !int_via_task) begin
            stack_push_valid_ff <= 1'b1;
            stack_push_data_ff  <= flags_ff;
         end else if (grp_op == SFR_GRP_PUSH32) begin
            stack_push_valid_ff <= 1'b1;
            stack_push_data_ff  <= flags_ff;
         end else if (grp_op == SFR_GRP_PUSH16) begin
            stack_push_valid_ff <= 1'b1;
            stack_push_data_ff  <= {16'h0000, flags_ff[15:0]};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         task_save_valid_ff <= 1'b0;
         task_save_data_ff  <= 32'h0000_0000;
      end else begin
         task_save_valid_ff <= 1'b0;
         if (task_suspend_req || (int_entry_req && int_via_task)) begin
            task_save_valid_ff <= 1'b1;
            task_save_data_ff  <= flags_ff;
         end
      end
   end

   assign cond_true     = cond_eval(cond_code, flags_ff);
   assign flags_word    = flags_ff;
   assign dir_step_down = flags_ff[BIT_DIR];
   assign int_enable    = flags_ff[BIT_INT_EN];

endmodule

// >>> verif/sfr_flags_sva.sv
// sfr_flags_sva: timing checks on the flags word block ports.
// assumes: one clock domain, rst_b async active low, bound to sfr_flags.
`timescale 1ns/1ps
module sfr_flags_chk
   import sfr_pkg::*;
(
   // clock and reset
   input wire logic           clk,
   input wire logic           rst_b,
   input wire logic           init_pin,
   // requests
   input wire sfr_alu_req_t   alu_req,
   input wire sfr_carry_cmd_t carry_cmd,
   input wire sfr_bt_req_t    bt_req,
   input wire sfr_grp_op_t    grp_op,
   input wire logic           task_suspend_req,
   input wire logic           task_load_req,
   input wire logic [31:0]    task_load_data,
   input wire logic           int_entry_req,
   input wire logic           int_via_task,
   // results
   input wire logic [31:0]    alu_result_ff,
   input wire logic           stack_push_valid_ff,
   input wire logic [31:0]    stack_push_data_ff,
   input wire logic           task_save_valid_ff,
   input wire logic [31:0]    task_save_data_ff,
   input wire logic [31:0]    flags_word,
   input wire logic           dir_step_down,
   input wire logic           int_enable,
   input wire logic           cond_true
);
   logic [1:0] ini_q_ff;
   logic       bt_bit_ff;
   logic       quiet;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) ini_q_ff <= 2'h0;
      else ini_q_ff <= {ini_q_ff[0], init_pin};
   end
   always_ff @(posedge clk) begin
      bt_bit_ff <= bt_req.operand[bt_req.index];
   end
   // init sync lags two edges, so its recent history must be clear too
   assign quiet = !task_load_req && grp_op == SFR_GRP_NONE && ini_q_ff == 2'h0 && !init_pin;
   property p_init; init_pin [*4] |=> flags_word == FLAGS_RESET; endproperty
   property p_rsvd; (flags_word & RSVD_MASK) == RSVD_ONES; endproperty
   property p_ctl;
      dir_step_down == flags_word[BIT_DIR] && int_enable == flags_word[BIT_INT_EN];
   endproperty
   property p_push; int_entry_req && !int_via_task
      |=> stack_push_valid_ff && stack_push_data_ff == $past(flags_word); endproperty
   property p_save; task_suspend_req
      |=> task_save_valid_ff && task_save_data_ff == $past(flags_word); endproperty
   property p_via; int_entry_req && int_via_task && grp_op == SFR_GRP_NONE
      |=> task_save_valid_ff && !stack_push_valid_ff; endproperty
   property p_load; task_load_req && ini_q_ff == 2'h0 && !init_pin
      |=> flags_word == (($past(task_load_data) & ~RSVD_MASK) | RSVD_ONES); endproperty
   property p_cpl; quiet && !alu_req.valid && !bt_req.valid && carry_cmd == SFR_CARRY_CPL
      |=> flags_word[BIT_CARRY] != $past(flags_word[BIT_CARRY]); endproperty
   property p_bt; quiet && !alu_req.valid && bt_req.valid
      |=> flags_word[BIT_CARRY] == bt_bit_ff; endproperty
   property p_zp; quiet && alu_req.valid |=> flags_word[BIT_ZERO] == (alu_result_ff == 32'h0)
      && flags_word[BIT_PARITY] == ~^alu_result_ff[7:0]; endproperty
   a_init: assert property (p_init) else $error("flags not reset by init");
   a_rsvd: assert property (p_rsvd) else $error("reserved flag bits wrong");
   a_ctl: assert property (p_ctl) else $error("control flag outputs wrong");
   a_push: assert property (p_push) else $error("handler push wrong");
   a_save: assert property (p_save) else $error("task save wrong");
   a_via: assert property (p_via) else $error("task handler save wrong");
   a_load: assert property (p_load) else $error("task load wrong");
   a_cpl: assert property (p_cpl) else $error("carry complement wrong");
   a_bt: assert property (p_bt) else $error("bit test carry wrong");
   a_zp: assert property (p_zp) else $error("zero or parity wrong");
   c_push: cover property (stack_push_valid_ff);
   c_save: cover property (task_save_valid_ff);
   c_cond: cover property (cond_true);
endmodule

bind sfr_flags sfr_flags_chk i_chk (.clk(clk), .rst_b(rst_b), .init_pin(init_pin),
   .alu_req(alu_req), .carry_cmd(carry_cmd), .bt_req(bt_req), .grp_op(grp_op),
   .task_suspend_req(task_suspend_req), .task_load_req(task_load_req),
   .task_load_data(task_load_data), .int_entry_req(int_entry_req),
   .int_via_task(int_via_task), .alu_result_ff(alu_result_ff),
   .stack_push_valid_ff(stack_push_valid_ff), .stack_push_data_ff(stack_push_data_ff),
   .task_save_valid_ff(task_save_valid_ff), .task_save_data_ff(task_save_data_ff),
   .flags_word(flags_word), .dir_step_down(dir_step_down), .int_enable(int_enable),
   .cond_true(cond_true));

// >>> verif/sfr_stack_model.sv
// sfr_stack_model: procedure stack top and task save area beside the block.
// assumes: pushes and saves arrive as one-cycle pulses from sfr_flags.
`timescale 1ns/1ps
module sfr_stack_model (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // from the block
   input wire logic        push_valid,
   input wire logic [31:0] push_data,
   input wire logic        save_valid,
   input wire logic [31:0] save_data,
   // stored words
   output logic [31:0]     top_word_ff,
   output logic [31:0]     saved_word_ff
);
   // popped word goes back untouched, reserved bits as read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) top_word_ff <= 32'h0;
      else if (push_valid) top_word_ff <= push_data;
   end
   // one save area; the outgoing task's word is reloaded later
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) saved_word_ff <= 32'h0;
      else if (save_valid) saved_word_ff <= save_data;
   end
endmodule

// >>> verif/testbench.sv
// testbench: directed checks of the flags word block through its request ports.
// assumes: sfr_pkg compiled first; checker bound separately.
`timescale 1ns/1ps
module testbench;
   import sfr_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, init_pin = 1'b0;
   logic dset = 1'b0, dclr = 1'b0, iset = 1'b0, iclr = 1'b0;
   logic tsus = 1'b0, tld = 1'b0, ient = 1'b0, ivia = 1'b0;
   sfr_alu_req_t   alu_req = '0;
   sfr_bt_req_t    bt_req = '0;
   sfr_carry_cmd_t ccmd = SFR_CARRY_NONE;
   sfr_grp_op_t    gop = SFR_GRP_NONE;
   logic [31:0] gdat = 32'h0, alu_res, bt_opd, pd, sd, flags, m_top, m_sav;
   logic [7:0]  acc_b;
   logic [3:0]  ccode = 4'h0;
   logic        pv, sv, ctrue, dsd, ien;
   int num_errors = 0, n_compared = 0, cyc = 0;
   // all flags set except reserved ones
   logic [31:0] w_all = (32'hFFFF_FFFF & ~RSVD_MASK) | RSVD_ONES;
   sfr_flags i_dut (.clk(clk), .rst_b(rst_b), .init_pin(init_pin), .alu_req(alu_req),
      .alu_result_ff(alu_res), .carry_cmd(ccmd), .bt_req(bt_req), .bt_operand_ff(bt_opd),
      .dir_set(dset), .dir_clear(dclr), .int_en_set(iset), .int_en_clear(iclr),
      .grp_op(gop), .grp_data_in(gdat), .acc_byte_ff(acc_b), .stack_push_valid_ff(pv),
      .stack_push_data_ff(pd), .task_suspend_req(tsus), .task_load_req(tld),
      .task_load_data(m_sav), .int_entry_req(ient), .int_via_task(ivia),
      .task_save_valid_ff(sv), .task_save_data_ff(sd), .cond_code(ccode),
      .cond_true(ctrue), .flags_word(flags), .dir_step_down(dsd), .int_enable(ien));
   sfr_stack_model i_stk (.clk(clk), .rst_b(rst_b), .push_valid(pv), .push_data(pd),
      .save_valid(sv), .save_data(sd), .top_word_ff(m_top), .saved_word_ff(m_sav));
   always #12.5 clk = ~clk;
   task automatic test_done;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 500) begin
         num_errors++;
         test_done();
      end
   end
   // wide enough to carry a valid bit beside a full word
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic alu(input sfr_alu_op_t op, input sfr_size_t sz,
                      input logic [31:0] a, b, r, f);
      alu_req = '{1'b1, op, sz, a, b};
      step();
      alu_req.valid = 1'b0;
      chk(alu_res, r);
      chk(flags, f);
   endtask
   task automatic cc(input sfr_carry_cmd_t c, input logic [31:0] f);
      ccmd = c;
      step();
      ccmd = SFR_CARRY_NONE;
      chk(flags, f);
   endtask
   task automatic bt(input sfr_bt_kind_t k, input logic [4:0] i, input logic [31:0] o, c, r);
      bt_req = '{1'b1, k, i, o};
      step();
      bt_req.valid = 1'b0;
      chk(flags[0], c);
      chk(bt_opd, r);
   endtask
   task automatic grp(input sfr_grp_op_t op, input logic [31:0] d);
      gop = op;
      gdat = d;
      step();
      gop = SFR_GRP_NONE;
   endtask
   task automatic conds(input logic [15:0] e);
      for (int i = 0; i < 16; i++) begin
         ccode = 4'(i);
         step();
         chk(ctrue, e[i]);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_b = 1'b1;
      chk(flags, FLAGS_RESET);
      chk(acc_b, 8'h02);
      alu(SFR_OP_ADD, SFR_SZ_8, 32'hFF, 32'h01, 32'h0, 32'h57);
      conds(16'h6656);
      alu(SFR_OP_SUB, SFR_SZ_32, 32'h0, 32'h1, 32'hFFFF_FFFF, 32'h97);
      alu(SFR_OP_ADD, SFR_SZ_8, 32'h7F, 32'h01, 32'h80, 32'h892);
      conds(16'hA9A9);
      cc(SFR_CARRY_SET, 32'h893);
      alu(SFR_OP_ADD_CARRY, SFR_SZ_16, 32'h0, 32'h0, 32'h1, 32'h02);
      cc(SFR_CARRY_SET, 32'h03);
      alu(SFR_OP_SUB_BORROW, SFR_SZ_8, 32'h0, 32'h0, 32'hFF, 32'h97);
      cc(SFR_CARRY_CPL, 32'h96);
      cc(SFR_CARRY_CPL, 32'h97);
      cc(SFR_CARRY_CLEAR, 32'h96);
      alu(SFR_OP_SUB, SFR_SZ_8, 32'h80, 32'h01, 32'h7F, 32'h812);
      alu(SFR_OP_OR, SFR_SZ_16, 32'h8000, 32'h0001, 32'h8001, 32'h82);
      alu(SFR_OP_AND, SFR_SZ_8, 32'hF0, 32'h0F, 32'h0, 32'h46);
      alu(SFR_OP_XOR, SFR_SZ_32, 32'hA5A5_A5A5, 32'hA5A5_A5A5, 32'h0, 32'h46);
      $display("test arith end");
      bt(SFR_BT_TEST, 5'h08, 32'h100, 32'h1, 32'h100);
      bt(SFR_BT_SET, 5'h1F, 32'h0, 32'h0, 32'h8000_0000);
      bt(SFR_BT_RESET, 5'h08, 32'h100, 32'h1, 32'h0);
      bt(SFR_BT_CPL, 5'h00, 32'h1, 32'h1, 32'h0);
      $display("test bits end");
      grp(SFR_GRP_STORE_ACC, 32'hFF);
      chk(flags, 32'hD7);
      grp(SFR_GRP_LOAD_ACC, 32'h0);
      chk(acc_b, 8'hD7);
      grp(SFR_GRP_POP32, 32'hFFFF_FFFF);
      chk(flags, w_all);
      grp(SFR_GRP_PUSH32, 32'h0);
      chk({pv, pd}, {1'b1, w_all});
      grp(SFR_GRP_POP16, 32'h0);
      chk(flags, w_all & 32'hFFFF_0002);
      grp(SFR_GRP_PUSH16, 32'h0);
      chk({pv, pd}, {1'b1, 32'h0000_0002});
      chk({dsd, ien}, 2'h0);
      grp(SFR_GRP_POP32, m_top);
      chk(flags, w_all);
      {dset, dclr, iclr} = 3'h7;
      step();
      {dset, dclr, iclr, iset} = 4'h9;
      chk({dsd, ien}, 2'h0);
      step();
      {dset, iset} = 2'h0;
      chk({dsd, ien}, 2'h3);
      $display("test group end");
      tsus = 1'b1;
      step();
      tsus = 1'b0;
      chk({sv, sd}, {1'b1, w_all});
      // control and system bits of the popped word survive the status update
      alu(SFR_OP_XOR, SFR_SZ_32, 32'h0, 32'h0, 32'h0, 32'h003F_7746);
      tld = 1'b1;
      step();
      {tld, ient} = 2'h1;
      chk(flags, w_all);
      step();
      ivia = 1'b1;
      chk({pv, pd}, {1'b1, w_all});
      step();
      {ient, ivia} = 2'h0;
      chk({sv, pv}, 2'h2);
      $display("test task end");
      init_pin = 1'b1;
      repeat (4) step();
      init_pin = 1'b0;
      chk(flags, FLAGS_RESET);
      $display("test init end");
      test_done();
   end
endmodule
